// File: core/aadc_channel.sv
// one acquisition channel: source select, downconverter, linked-list dma
`timescale 1ns/100ps
module aadc_channel
  import aadc_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic                        sample_valid_in,
  input  wire logic signed [ADC_W-1:0]     adc0_in,
  input  wire logic signed [ADC_W-1:0]     adc1_in,
  input  wire logic signed [ADC_W-1:0]     test_in,
  input  wire logic        [1:0]           src_sel_in,
  input  wire logic        [TUNE_W-1:0]    tune_in,
  input  wire logic        [DECIM_W-1:0]   decim_in,
  input  wire logic                        fmt_short_in,
  input  wire logic                        coef_wr_in,
  input  wire logic        [TAP_IDX_W-1:0] coef_addr_in,
  input  wire logic signed [COEF_W-1:0]    coef_data_in,
  input  wire logic                        link_wr_in,
  input  wire logic        [LINK_IDX_W-1:0] link_addr_in,
  input  wire logic        [LNK_W-1:0]     link_data_in,
  input  wire logic                        dma_start_in,
  input  wire logic        [LINK_IDX_W-1:0] dma_head_in,
  input  wire logic                        gate_in,
  input  wire logic                        tx_ready_in,
  output logic                             tx_valid_out,
  output logic             [WORD_W-1:0]    tx_data_out,
  output logic                             tx_meta_out,
  output logic                             dma_busy_out,
  output logic                             dma_done_out,
  output logic                             overrun_out
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ARM,
    ST_XFER,
    ST_META_TS,
    ST_META_LEN,
    ST_LINK_END
  } aadc_state_e;

  // reset release synchroniser
  logic [RST_STAGES-1:0] rst_sync_reg;
  logic                  rst_n;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[RST_STAGES-1];

  // input selector
  logic signed [ADC_W-1:0] sel_sample;

  always_comb begin
    unique case (src_sel_in)
      AADC_SRC_ADC0: sel_sample = adc0_in;
      AADC_SRC_ADC1: sel_sample = adc1_in;
      default:       sel_sample = test_in; // unused code falls to the test signal
    endcase
  end

  // downconverter: mixer, then one filter per rail
  aadc_iq_if #(.W(MIX_W)) mix_if ();

  aadc_mixer u_mixer (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .sample_valid_in (sample_valid_in),
    .sample_in       (sel_sample),
    .tune_in         (tune_in),
    .mix             (mix_if.src)
  );

  logic                    fil_i_valid;
  logic signed [OUT_W-1:0] fil_i, fil_q;

  aadc_decim_filter u_filt_i (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .sample_valid_in (mix_if.valid),
    .sample_in       (mix_if.i),
    .decim_in        (decim_in),
    .coef_wr_in      (coef_wr_in),
    .coef_addr_in    (coef_addr_in),
    .coef_data_in    (coef_data_in),
    .out_valid_out   (fil_i_valid),
    .out_data_out    (fil_i)
  );

  aadc_decim_filter u_filt_q (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .sample_valid_in (mix_if.valid),
    .sample_in       (mix_if.q),
    .decim_in        (decim_in),
    .coef_wr_in      (coef_wr_in),
    .coef_addr_in    (coef_addr_in),
    .coef_data_in    (coef_data_in),
    .out_valid_out   (),
    .out_data_out    (fil_q)
  );

  // both rails share the decimation phase, so one valid serves both
  logic [WORD_W-1:0] sample_word;

  always_comb begin
    if (fmt_short_in) begin
      sample_word = {32'h0000_0000, fil_i[OUT_W-1 -: SHORT_W],
                     fil_q[OUT_W-1 -: SHORT_W]};
    end else begin
      sample_word = {{8{fil_i[OUT_W-1]}}, fil_i, {8{fil_q[OUT_W-1]}}, fil_q};
    end
  end

  // descriptor table
  logic [LNK_W-1:0] link_mem [LINKS];

  always_ff @(posedge clk_in) begin
    if (link_wr_in) link_mem[link_addr_in] <= link_data_in;
  end

  // sample-accurate time base at the converter rate
  logic [TS_W-1:0] ts_reg, ts_next;

  always_comb begin
    ts_next = ts_reg;
    if (sample_valid_in) ts_next = ts_reg + TS_W'(1);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) ts_reg <= '0;
    else        ts_reg <= ts_next;
  end

  // dma engine
  aadc_state_e           state_reg, state_next;
  logic [LNK_W-1:0]      link_reg, link_next;
  logic [LINK_IDX_W-1:0] idx_reg, idx_next;
  logic [LEN_W-1:0]      count_reg, count_next;
  logic [TS_W-1:0]       ts_first_reg, ts_first_next;
  logic [1:0]            src_reg, src_next;
  logic                  tx_valid_reg, tx_valid_next;
  logic [WORD_W-1:0]     tx_data_reg, tx_data_next;
  logic                  tx_meta_reg, tx_meta_next;
  logic                  done_reg, done_next;
  logic                  ovr_reg, ovr_next;
  logic                  slot_free, gate_mode, xfer_end;
  logic [LEN_W-1:0]      link_len;

  always_comb begin
    slot_free     = !tx_valid_reg || tx_ready_in;
    gate_mode     = link_reg[LNK_GATE_BIT];
    link_len      = link_reg[LNK_LEN_LSB +: LEN_W];
    state_next    = state_reg;
    link_next     = link_reg;
    idx_next      = idx_reg;
    count_next    = count_reg;
    ts_first_next = ts_first_reg;
    src_next      = src_reg;
    tx_valid_next = tx_valid_reg && !tx_ready_in;
    tx_data_next  = tx_data_reg;
    tx_meta_next  = tx_meta_reg;
    done_next     = 1'b0;
    ovr_next      = ovr_reg;
    xfer_end      = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (dma_start_in) begin
          idx_next   = dma_head_in;
          ovr_next   = 1'b0;
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        link_next  = link_mem[idx_reg];
        count_next = '0;
        src_next   = src_sel_in;
        state_next = ST_ARM;
      end
      ST_ARM: begin
        // gated descriptors wait for the gate; fixed ones start at once
        if (!gate_mode || gate_in) state_next = ST_XFER;
      end
      ST_XFER: begin
        if (fil_i_valid) begin
          if (slot_free) begin
            tx_valid_next = 1'b1;
            tx_data_next  = sample_word;
            tx_meta_next  = 1'b0;
            count_next    = count_reg + LEN_W'(1);
            if (count_reg == '0) ts_first_next = ts_reg;
          end else begin
            // no buffer here: a stalled host loses samples, flagged
            ovr_next = 1'b1;
          end
        end
        if (gate_mode) begin
          xfer_end = !gate_in;
        end else begin
          xfer_end = (count_next >= link_len);
        end
        if (xfer_end) begin
          state_next = link_reg[LNK_META_BIT] ? ST_META_TS : ST_LINK_END;
        end
      end
      ST_META_TS: begin
        if (slot_free) begin
          tx_valid_next = 1'b1;
          tx_data_next  = ts_first_reg;
          tx_meta_next  = 1'b1;
          state_next    = ST_META_LEN;
        end
      end
      ST_META_LEN: begin
        if (slot_free) begin
          tx_valid_next = 1'b1;
          tx_data_next  = {ID_W'(src_reg), 24'h00_0000, count_reg};
          tx_meta_next  = 1'b1;
          state_next    = ST_LINK_END;
        end
      end
      ST_LINK_END: begin
        if (link_reg[LNK_LAST_BIT]) begin
          // done only once the last word has left, so done means drained
          if (slot_free) begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        end else begin
          idx_next   = link_reg[LNK_NEXT_LSB +: LINK_IDX_W];
          state_next = ST_FETCH;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      link_reg     <= '0;
      idx_reg      <= '0;
      count_reg    <= '0;
      ts_first_reg <= '0;
      src_reg      <= '0;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= '0;
      tx_meta_reg  <= 1'b0;
      done_reg     <= 1'b0;
      ovr_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      link_reg     <= link_next;
      idx_reg      <= idx_next;
      count_reg    <= count_next;
      ts_first_reg <= ts_first_next;
      src_reg      <= src_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg  <= tx_data_next;
      tx_meta_reg  <= tx_meta_next;
      done_reg     <= done_next;
      ovr_reg      <= ovr_next;
    end
  end

  logic busy_reg, busy_next;

  always_comb begin
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) busy_reg <= 1'b0;
    else        busy_reg <= busy_next;
  end

  assign tx_valid_out = tx_valid_reg;
  assign tx_data_out  = tx_data_reg;
  assign tx_meta_out  = tx_meta_reg;
  assign dma_busy_out = busy_reg;
  assign dma_done_out = done_reg;
  assign overrun_out  = ovr_reg;

endmodule // aadc_channel

// File: core/aadc_pkg.sv
// shared constants and types for the acquisition and downconverter channel
package aadc_pkg;

  localparam int ADC_W      = 14;
  localparam int MIX_W      = 15;
  localparam int LUT_W      = 12;
  localparam int LUT_IDX_W  = 4;
  localparam int TUNE_W     = 32;
  localparam int COEF_W     = 16;
  localparam int TAPS       = 16;
  localparam int TAP_IDX_W  = 4;
  localparam int OUT_W      = 24;
  localparam int SHORT_W    = 16;
  localparam int DECIM_W    = 17;
  localparam int DECIM_MIN  = 2;
  localparam int DECIM_MAX  = 65536;
  localparam int PROD_W     = MIX_W + COEF_W;
  localparam int ACC_W      = PROD_W + TAP_IDX_W;
  localparam int ACC_LSB    = 7;
  localparam int MIX_LSB    = 11;
  localparam int COS_OFFSET = 4;

  localparam int LINKS      = 16;
  localparam int LINK_IDX_W = 4;
  localparam int LEN_W      = 32;
  localparam int TS_W       = 64;
  localparam int WORD_W     = 64;
  localparam int ID_W       = 8;
  localparam int RST_STAGES = 2;

  // link descriptor layout
  localparam int LNK_LEN_LSB  = 0;
  localparam int LNK_NEXT_LSB = 32;
  localparam int LNK_GATE_BIT = 36;
  localparam int LNK_META_BIT = 37;
  localparam int LNK_LAST_BIT = 38;
  localparam int LNK_W        = 39;

  typedef enum logic [1:0] {
    AADC_SRC_ADC0,
    AADC_SRC_ADC1,
    AADC_SRC_TEST
  } aadc_src_e;

  typedef logic signed [COEF_W-1:0] aadc_coef_t;
  typedef logic signed [LUT_W-1:0]  aadc_lut_t;

  // short symmetric lowpass, unity gain near 2^15
  localparam aadc_coef_t DEF_COEF [TAPS] = '{
    16'hFF88, 16'hFED4, 16'hFE84, 16'h0000, 16'h0514, 16'h0CE4, 16'h1450, 16'h1964,
    16'h1964, 16'h1450, 16'h0CE4, 16'h0514, 16'h0000, 16'hFE84, 16'hFED4, 16'hFF88
  };

  // one full sine period in sixteen steps
  localparam aadc_lut_t SIN_LUT [16] = '{
    12'h000, 12'h30F, 12'h5A7, 12'h763, 12'h7FF, 12'h763, 12'h5A7, 12'h30F,
    12'h000, 12'hCF1, 12'hA59, 12'h89D, 12'h801, 12'h89D, 12'hA59, 12'hCF1
  };

endpackage

// File: core/aadc_iq_if.sv
// complex sample stream between the mixer and the channel top
`timescale 1ns/100ps
interface aadc_iq_if #(
  parameter int W = 15
);
  logic                valid;
  logic signed [W-1:0] i;
  logic signed [W-1:0] q;

  modport src (output valid, output i, output q);
  modport dst (input valid, input i, input q);
endinterface

// File: core/aadc_mixer.sv
// phase accumulator and quadrature mixer of the downconverter
`timescale 1ns/100ps
module aadc_mixer
  import aadc_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     sample_valid_in,
  input  wire logic signed [ADC_W-1:0]  sample_in,
  input  wire logic        [TUNE_W-1:0] tune_in,
  aadc_iq_if.src                        mix
);

  logic [TUNE_W-1:0]        phase_reg, phase_next;
  logic                     valid_reg, valid_next;
  logic signed [MIX_W-1:0]  i_reg, i_next, q_reg, q_next;
  logic [LUT_IDX_W-1:0]     sin_idx, cos_idx;
  logic signed [ADC_W+LUT_W-1:0] prod_i, prod_q;

  always_comb begin
    sin_idx    = phase_reg[TUNE_W-1 -: LUT_IDX_W];
    cos_idx    = sin_idx + LUT_IDX_W'(COS_OFFSET);
    prod_i     = sample_in * SIN_LUT[cos_idx];
    prod_q     = -(sample_in * SIN_LUT[sin_idx]);
    phase_next = phase_reg;
    valid_next = sample_valid_in;
    i_next     = i_reg;
    q_next     = q_reg;
    if (sample_valid_in) begin
      phase_next = phase_reg + tune_in;
      i_next     = prod_i[MIX_LSB +: MIX_W];
      q_next     = prod_q[MIX_LSB +: MIX_W];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= '0;
      valid_reg <= 1'b0;
      i_reg     <= '0;
      q_reg     <= '0;
    end else begin
      phase_reg <= phase_next;
      valid_reg <= valid_next;
      i_reg     <= i_next;
      q_reg     <= q_next;
    end
  end

  assign mix.valid = valid_reg;
  assign mix.i     = i_reg;
  assign mix.q     = q_reg;

endmodule // aadc_mixer

// File: core/aadc_decim_filter.sv
// decimating fir for one rail, loadable coefficients
`timescale 1ns/100ps
module aadc_decim_filter
  import aadc_pkg::*;
#(
  parameter int N_TAPS = TAPS
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        sample_valid_in,
  input  wire logic signed [MIX_W-1:0]     sample_in,
  input  wire logic        [DECIM_W-1:0]   decim_in,
  input  wire logic                        coef_wr_in,
  input  wire logic        [TAP_IDX_W-1:0] coef_addr_in,
  input  wire logic signed [COEF_W-1:0]    coef_data_in,
  output logic                             out_valid_out,
  output logic signed      [OUT_W-1:0]     out_data_out
);

  // the default table and the tap address width are both fixed at sixteen
  if (N_TAPS != TAPS) begin : g_taps_check
    $error("aadc_decim_filter: tap count must match the default table");
  end

  logic signed [COEF_W-1:0] coef_mem [N_TAPS];
  logic signed [MIX_W-1:0]  line_reg [N_TAPS];
  logic [DECIM_W-1:0]       phase_reg, phase_next, decim_eff;
  logic                     valid_reg, valid_next;
  logic signed [OUT_W-1:0]  data_reg, data_next;
  logic signed [ACC_W-1:0]  acc;

  // coefficients come up as the default lowpass after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < N_TAPS; k++) coef_mem[k] <= DEF_COEF[k];
    end else if (coef_wr_in) begin
      coef_mem[coef_addr_in] <= coef_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < N_TAPS; k++) line_reg[k] <= '0;
    end else if (sample_valid_in) begin
      line_reg[0] <= sample_in;
      for (int k = 1; k < N_TAPS; k++) line_reg[k] <= line_reg[k-1];
    end
  end

  always_comb begin
    acc = '0;
    for (int k = 0; k < N_TAPS; k++) begin
      acc = acc + ACC_W'(line_reg[k] * coef_mem[k]);
    end
    // out-of-range factors clamp rather than stall the stream
    decim_eff = decim_in;
    if (decim_in < DECIM_W'(DECIM_MIN)) decim_eff = DECIM_W'(DECIM_MIN);
    if (decim_in > DECIM_W'(DECIM_MAX)) decim_eff = DECIM_W'(DECIM_MAX);
    phase_next = phase_reg;
    valid_next = 1'b0;
    data_next  = data_reg;
    if (sample_valid_in) begin
      if (phase_reg >= decim_eff - DECIM_W'(1)) begin
        phase_next = '0;
        valid_next = 1'b1;
        data_next  = acc[ACC_LSB +: OUT_W];
      end else begin
        phase_next = phase_reg + DECIM_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= '0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      phase_reg <= phase_next;
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  assign out_valid_out = valid_reg;
  assign out_data_out  = data_reg;

endmodule // aadc_decim_filter

// File: tb/aadc_channel_monitor.sv
// concurrent checks on the stream and dma status ports of the channel
`timescale 1ns/100ps
module aadc_channel_monitor
  import aadc_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              arst_n_in,
  input wire logic              dma_start_in,
  input wire logic              fmt_short_in,
  input wire logic              tx_ready_in,
  input wire logic              tx_valid_out,
  input wire logic [WORD_W-1:0] tx_data_out,
  input wire logic              tx_meta_out,
  input wire logic              dma_busy_out,
  input wire logic              dma_done_out,
  input wire logic              overrun_out
);
  logic meta_odd_reg;
  logic meta_odd_next;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // metadata comes in pairs, the odd one carries the length
  always_comb begin
    meta_odd_next = meta_odd_reg ^ (tx_valid_out & tx_ready_in & tx_meta_out);
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_odd_reg <= 1'b0;
    end else begin
      meta_odd_reg <= meta_odd_next;
    end
  end

  a_tx_word_hold: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_meta_out))
    else $error("stream word changed before it was taken");
  a_start_sets_busy: assert property (dma_start_in && !dma_busy_out |=> dma_busy_out)
    else $error("busy did not rise after start");
  a_done_one_cycle: assert property (dma_done_out |=> !dma_done_out)
    else $error("done lasted more than one cycle");
  a_busy_fall_done: assert property ($fell(dma_busy_out) |-> dma_done_out)
    else $error("busy dropped without done");
  a_done_all_taken: assert property (dma_done_out |-> !dma_busy_out && !tx_valid_out)
    else $error("done while engine still active");
  a_valid_in_busy: assert property (tx_valid_out |-> dma_busy_out)
    else $error("word offered while idle");
  a_start_clr_overrun: assert property (dma_start_in && !dma_busy_out |=> !overrun_out)
    else $error("overrun not cleared by start");
  a_short_upper_zero: assert property (tx_valid_out && !tx_meta_out && fmt_short_in |->
    tx_data_out[63:32] == 32'h0)
    else $error("short format upper half not zero");
  a_long_sign_ext: assert property (tx_valid_out && !tx_meta_out && !fmt_short_in |->
    tx_data_out[63:56] == {8{tx_data_out[55]}} && tx_data_out[31:24] == {8{tx_data_out[23]}})
    else $error("long format rails not sign extended");
  a_meta_len_layout: assert property (tx_valid_out && tx_meta_out && meta_odd_reg |->
    tx_data_out[55:32] == 24'h0)
    else $error("length word padding not zero");

  c_done: cover property (dma_done_out);
  c_overrun: cover property (overrun_out);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
  c_meta: cover property (tx_valid_out && tx_meta_out && meta_odd_reg);
endmodule // aadc_channel_monitor

bind aadc_channel aadc_channel_monitor mon_u (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .dma_start_in(dma_start_in),
  .fmt_short_in(fmt_short_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .tx_meta_out(tx_meta_out), .dma_busy_out(dma_busy_out),
  .dma_done_out(dma_done_out), .overrun_out(overrun_out)
);

// File: tb/aadc_host_model.sv
// host end of the stream: takes words, can stall on request
`timescale 1ns/100ps
module aadc_host_model
  import aadc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              stall_in,
  input  wire logic              tx_valid_in,
  input  wire logic [WORD_W-1:0] tx_data_in,
  input  wire logic              tx_meta_in,
  output logic                   tx_ready_out
);
  logic [WORD_W-1:0] data_q[$];
  logic [WORD_W-1:0] meta_q[$];
  int                stamp_q[$];
  int                cyc = 0;

  initial tx_ready_out = 1'b0;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (tx_valid_in === 1'b1 && tx_ready_out) begin
      if (tx_meta_in) begin
        meta_q.push_back(tx_data_in);
      end else begin
        data_q.push_back(tx_data_in);
        stamp_q.push_back(cyc);
      end
    end
    tx_ready_out <= #1 !stall_in;
  end
endmodule // aadc_host_model

// File: tb/tb.sv
// self-checking bench for one acquisition channel
`timescale 1ns/100ps
module tb
  import aadc_pkg::*;
;
  logic clk_in, arst_n_in, sample_valid_in, fmt_short_in, coef_wr_in, link_wr_in;
  logic dma_start_in, gate_in, tx_ready_in, stall, tx_valid_out, tx_meta_out;
  logic dma_busy_out, dma_done_out, overrun_out;
  logic signed [ADC_W-1:0]      adc0_in, adc1_in, test_in;
  logic        [1:0]            src_sel_in;
  logic        [TUNE_W-1:0]     tune_in;
  logic        [DECIM_W-1:0]    decim_in;
  logic        [TAP_IDX_W-1:0]  coef_addr_in;
  logic signed [COEF_W-1:0]     coef_data_in;
  logic        [LINK_IDX_W-1:0] link_addr_in, dma_head_in;
  logic        [LNK_W-1:0]      link_data_in;
  logic        [WORD_W-1:0]     tx_data_out;
  logic signed [31:0]           iv, qv;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int k;

  aadc_channel dut_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .sample_valid_in(sample_valid_in),
    .adc0_in(adc0_in), .adc1_in(adc1_in), .test_in(test_in), .src_sel_in(src_sel_in),
    .tune_in(tune_in), .decim_in(decim_in), .fmt_short_in(fmt_short_in),
    .coef_wr_in(coef_wr_in), .coef_addr_in(coef_addr_in), .coef_data_in(coef_data_in),
    .link_wr_in(link_wr_in), .link_addr_in(link_addr_in), .link_data_in(link_data_in),
    .dma_start_in(dma_start_in), .dma_head_in(dma_head_in), .gate_in(gate_in),
    .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .tx_meta_out(tx_meta_out), .dma_busy_out(dma_busy_out), .dma_done_out(dma_done_out),
    .overrun_out(overrun_out)
  );
  aadc_host_model host_u (
    .clk_in(clk_in), .stall_in(stall), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_meta_in(tx_meta_out), .tx_ready_out(tx_ready_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // whole run is under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [LNK_W-1:0] lnk(input logic [31:0] len, input logic [3:0] nxt,
                                           input logic g, input logic m, input logic l);
    lnk = {l, m, g, nxt, len};
  endfunction

  task automatic wr_link(input logic [3:0] a, input logic [LNK_W-1:0] d);
    @(posedge clk_in);
    #1 link_wr_in = 1'b1;
    link_addr_in = a;
    link_data_in = d;
    @(posedge clk_in);
    #1 link_wr_in = 1'b0;
  endtask

  task automatic wr_coef(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1 coef_wr_in = 1'b1;
    coef_addr_in = a;
    coef_data_in = d;
    @(posedge clk_in);
    #1 coef_wr_in = 1'b0;
  endtask

  // start at a descriptor and wait for the done pulse
  task automatic run(input logic [3:0] head);
    int i;
    host_u.data_q.delete();
    host_u.meta_q.delete();
    host_u.stamp_q.delete();
    @(posedge clk_in);
    #1 dma_start_in = 1'b1;
    dma_head_in = head;
    @(posedge clk_in);
    #1 dma_start_in = 1'b0;
    chk("busy", 64'h1, {63'h0, dma_busy_out});
    for (i = 0; i < 4000 && dma_done_out !== 1'b1; i++) @(negedge clk_in);
    chk("done", 64'h1, {63'h0, dma_done_out});
    chk("idle", 64'h0, {63'h0, dma_busy_out});
  endtask

  task automatic split(input logic [63:0] d);
    iv = fmt_short_in ? 32'($signed(d[31:16])) : d[63:32];
    qv = fmt_short_in ? 32'($signed(d[15:0])) : d[31:0];
  endtask

  initial begin
    {arst_n_in, sample_valid_in, fmt_short_in, coef_wr_in, link_wr_in} = '0;
    {dma_start_in, gate_in, stall, src_sel_in, tune_in} = '0;
    {adc0_in, adc1_in, test_in, coef_addr_in, coef_data_in} = '0;
    {link_addr_in, dma_head_in, link_data_in} = '0;
    decim_in = 17'h00002;
    repeat (6) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    sample_valid_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    // opposite signs on the unused sources expose a wrong pick
    // code 3 also picks the test signal, so all four codes are run
    for (int s = 0; s < 8; s++) begin
      src_sel_in = 2'(s % 4);
      fmt_short_in = 1'(s / 4);
      adc0_in = (s % 4 == 0) ? 14'h0FA0 : 14'h3060;
      adc1_in = (s % 4 == 1) ? 14'h0FA0 : 14'h3060;
      test_in = (s % 4 >= 2) ? 14'h0FA0 : 14'h3060;
      wr_link(4'h0, lnk(32'h2, 4'h0, 1'b0, 1'b1, 1'b1));
      repeat (40) @(posedge clk_in);
      run(4'h0);
      split(host_u.data_q[0]);
      chk("q_rail", 64'h0, 64'(qv));
      chk("i_sign", 64'h1, 64'(iv > 0));
      chk("words", 64'h2, 64'(host_u.data_q.size()));
      chk("spacing", 64'h2, 64'(host_u.stamp_q[1] - host_u.stamp_q[0]));
      chk("len_word", {8'(s % 4), 24'h0, 32'h2}, host_u.meta_q[1]);
    end
    $display("test source and format finished");
    fmt_short_in = 1'b0;
    for (int t = 0; t < 2; t++) begin
      tune_in = t ? 32'h4000_0000 : 32'h8000_0000;
      repeat (40) @(posedge clk_in);
      run(4'h0);
      split(host_u.data_q[0]);
      chk("q_zero", t ? 64'h0 : 64'h1, 64'(qv == 0));
    end
    $display("test tuning finished");
    wr_link(4'h1, lnk(32'h3, 4'h0, 1'b0, 1'b0, 1'b1));
    for (int d = 0; d < 2; d++) begin
      decim_in = d ? 17'h00008 : 17'h00001;
      run(4'h1);
      chk("decim", d ? 64'h8 : 64'h2, 64'(host_u.stamp_q[2] - host_u.stamp_q[1]));
    end
    decim_in = 17'h00002;
    $display("test decimation finished");
    wr_link(4'h3, lnk(32'h0, 4'h4, 1'b1, 1'b1, 1'b0));
    wr_link(4'h4, lnk(32'h3, 4'h0, 1'b0, 1'b1, 1'b1));
    fork
      run(4'h3);
      begin
        repeat (20) @(posedge clk_in);
        #1 gate_in = 1'b1;
        repeat (16) @(posedge clk_in);
        #1 gate_in = 1'b0;
      end
    join
    k = host_u.data_q.size() - 3;
    chk("gate_len", 64'(k), {32'h0, host_u.meta_q[1][31:0]});
    chk("gate_span", 64'h1, 64'(k >= 7 && k <= 9));
    chk("next_len", 64'h3, {32'h0, host_u.meta_q[3][31:0]});
    chk("stamp_order", 64'h1, 64'(host_u.meta_q[2] > host_u.meta_q[0]));
    $display("test gate chain finished");
    wr_link(4'h0, lnk(32'h4, 4'h0, 1'b0, 1'b0, 1'b1));
    fork
      run(4'h0);
      begin
        stall = 1'b1;
        repeat (20) @(negedge clk_in);
        chk("overrun", 64'h1, {63'h0, overrun_out});
        @(posedge clk_in);
        #1 stall = 1'b0;
      end
    join
    chk("kept", 64'h4, 64'(host_u.data_q.size()));
    $display("test stall finished");
    for (int c = 0; c < TAPS; c++) wr_coef(4'(c), 16'h0000);
    repeat (40) @(posedge clk_in);
    run(4'h1);
    chk("zero_taps", 64'h0, host_u.data_q[0]);
    $display("test coefficients finished");
    end_sim();
  end
endmodule // tb
